// [src/acs_adc_sequencer.sv]
// Operation
// - start flag launches one conversion, self-clears
// - channel change waits for last cycle of running conversion
// - selected trigger edge resets prescaler, starts
// - edges during conversion and held levels ignored
// - source flag must clear before retriggering
// - done-flag source runs free after first start
// - start flag works and reads busy under auto
// - prescaler runs only while converter enabled
// - software start waits for next converter rise
// - conversion 13 cycles, first one 25
// - sample-hold at 1.5, first at 13.5
// - completion stores result, sets done, clears start
// - auto: sample-hold at 2, length 13.5
// - free running keeps start flag high
// - differential start with sync high takes 14
// - free-running differential restarts take 14
// - low-byte read locks result until high read
// - selection tracks until start, resumes last cycle
`timescale 1ns/1ps
`default_nettype none
module acs_adc_sequencer (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // avalon-mm slave
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // trigger source flags
  input wire logic [6:0] i_trig_src,
  // analog core
  input wire logic [9:0] i_core_result,
  output logic o_core_enable,
  output logic o_conv_active,
  output logic o_sample_hold,
  output logic [7:0] o_core_sel,
  output logic o_half_rate_sync_clock
);

  acs_pkg::acs_state_t state_r, state_nxt;
  logic en_r, auto_r, diff_r, done_r, start_pend_r, lock_r, first_r;
  logic ack_r, sh_r, trig_d_r;
  logic [2:0] ps_r, ts_r;
  logic [7:0] insel_r, active_sel_r;
  logic [9:0] result_r;
  logic [5:0] hc_r, hc_nxt, end_r, sh_at_r, end_nxt, sh_nxt;
  logic [6:0] trig_s1_r, trig_s2_r;
  logic [31:0] rdata_r;
  logic p_rise, p_fall, p_sync;

  function automatic logic [5:0] conv_end(input logic first, input logic ext);
    conv_end = (first ? acs_pkg::FIRST_HALF : acs_pkg::NORMAL_HALF)
             + (ext ? acs_pkg::DIFF_EXTRA_HALF : 6'h00);
  endfunction : conv_end

  function automatic logic [5:0] conv_sh(input logic first, input logic ext);
    conv_sh = (first ? acs_pkg::SH_FIRST_HALF : acs_pkg::SH_NORMAL_HALF)
            + (ext ? acs_pkg::DIFF_EXTRA_HALF : 6'h00);
  endfunction : conv_sh

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire req = i_avs_read | i_avs_write;
  wire wr_en = i_avs_write & ack_r & i_avs_byteenable[0];
  wire rd_en = i_avs_read & ack_r;
  wire wr_a = wr_en & (i_avs_address == acs_pkg::ADDR_CTRL_A);
  wire wr_b = wr_en & (i_avs_address == acs_pkg::ADDR_CTRL_B);
  wire wr_s = wr_en & (i_avs_address == acs_pkg::ADDR_INSEL);
  wire rd_lo = rd_en & (i_avs_address == acs_pkg::ADDR_RES_LO);
  wire rd_hi = rd_en & (i_avs_address == acs_pkg::ADDR_RES_HI);
  wire sw_start = wr_a & i_avs_writedata[acs_pkg::CA_START]
                & i_avs_writedata[acs_pkg::CA_EN];
  wire done_clr = wr_a & i_avs_writedata[acs_pkg::CA_DONE];
  wire en_off = wr_a & ~i_avs_writedata[acs_pkg::CA_EN];

  // ----------------------------------------------------------------
  // sequencing terms
  // ----------------------------------------------------------------
  wire idle = (state_r == acs_pkg::ST_IDLE);
  wire conv = (state_r == acs_pkg::ST_CONV);
  wire step = p_rise | p_fall;
  wire [7:0] trig_vec = {done_r, trig_s2_r};
  wire trig_lvl = trig_vec[ts_r];
  wire trig_edge = trig_lvl & ~trig_d_r;
  wire auto_go = en_r & auto_r & trig_edge & idle;
  wire sw_go = en_r & start_pend_r & p_rise & idle & ~auto_go;
  wire finish = conv & step & (hc_r + 6'h01 == end_r);
  wire free_run = auto_r & (ts_r == acs_pkg::TS_DONE);
  wire restart = finish & free_run & en_r;
  wire ext = diff_r & p_sync;
  wire track = idle | (hc_r + 6'h02 >= end_r);
  wire start_flag = start_pend_r | conv;
  wire [31:0] rd_mux =
      (i_avs_address == acs_pkg::ADDR_CTRL_A) ?
        {25'h0000000, ps_r, done_r, auto_r, start_flag, en_r} :
      (i_avs_address == acs_pkg::ADDR_CTRL_B) ? {28'h0000000, diff_r, ts_r} :
      (i_avs_address == acs_pkg::ADDR_INSEL) ? {24'h000000, insel_r} :
      (i_avs_address == acs_pkg::ADDR_RES_LO) ? {24'h000000, result_r[7:0]} :
      (i_avs_address == acs_pkg::ADDR_RES_HI) ? {30'h00000000, result_r[9:8]} :
      (i_avs_address == acs_pkg::ADDR_STATUS) ?
        {16'h0000, active_sel_r, 5'h00, p_sync, lock_r, conv} :
      32'h00000000;

  assign o_avs_waitrequest = req & ~ack_r;
  assign o_avs_readdata = rdata_r;
  assign o_core_enable = en_r;
  assign o_conv_active = conv;
  assign o_sample_hold = sh_r;
  assign o_core_sel = active_sel_r;
  assign o_half_rate_sync_clock = p_sync;

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  acs_prescaler u_presc (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_run(en_r),
    .i_clr(auto_go),
    .i_ps(ps_r),
    .o_rise(p_rise),
    .o_fall(p_fall),
    .o_sync(p_sync)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    hc_nxt = hc_r;
    end_nxt = end_r;
    sh_nxt = sh_at_r;
    case (state_r)
      acs_pkg::ST_IDLE: begin
        if (auto_go) begin
          state_nxt = acs_pkg::ST_CONV;
          hc_nxt = 6'h00;
          end_nxt = acs_pkg::AUTO_HALF;
          sh_nxt = acs_pkg::AUTO_SH_HALF;
        end else if (sw_go) begin
          state_nxt = acs_pkg::ST_CONV;
          hc_nxt = 6'h00;
          end_nxt = conv_end(first_r, ext);
          sh_nxt = conv_sh(first_r, ext);
        end
      end
      acs_pkg::ST_CONV: begin
        if (restart) begin
          hc_nxt = 6'h00;
          end_nxt = conv_end(1'b0, ext);
          sh_nxt = conv_sh(1'b0, ext);
        end else if (finish) begin
          state_nxt = acs_pkg::ST_IDLE;
        end else if (step) begin
          hc_nxt = hc_r + 6'h01;
        end
      end
      default: begin
        state_nxt = acs_pkg::ST_IDLE;
      end
    endcase
    if (!en_r) begin
      state_nxt = acs_pkg::ST_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // bus handshake and control registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h00000000;
      en_r <= 1'b0;
      auto_r <= 1'b0;
      ps_r <= acs_pkg::PS_RST;
      ts_r <= acs_pkg::TS_RST;
      diff_r <= 1'b0;
      insel_r <= acs_pkg::INSEL_RST;
    end else begin
      ack_r <= req & ~ack_r;
      rdata_r <= (i_avs_read & ~ack_r) ? rd_mux : rdata_r;
      if (wr_a) begin
        en_r <= i_avs_writedata[acs_pkg::CA_EN];
        auto_r <= i_avs_writedata[acs_pkg::CA_AUTO];
        ps_r <= i_avs_writedata[acs_pkg::CA_PS_LSB +: 3];
      end
      if (wr_b) begin
        ts_r <= i_avs_writedata[acs_pkg::CB_TS_LSB +: 3];
        diff_r <= i_avs_writedata[acs_pkg::CB_DIFF];
      end
      if (wr_s) begin
        insel_r <= i_avs_writedata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r <= acs_pkg::ST_IDLE;
      hc_r <= 6'h00;
      end_r <= acs_pkg::NORMAL_HALF;
      sh_at_r <= acs_pkg::SH_NORMAL_HALF;
      sh_r <= 1'b0;
      first_r <= 1'b1;
      start_pend_r <= 1'b0;
      active_sel_r <= acs_pkg::INSEL_RST;
    end else begin
      state_r <= state_nxt;
      hc_r <= hc_nxt;
      end_r <= end_nxt;
      sh_at_r <= sh_nxt;
      sh_r <= conv & step & (hc_r + 6'h01 == sh_at_r);
      first_r <= ~en_r | (first_r & ~finish);
      start_pend_r <= sw_start | (en_r & start_pend_r & ~sw_go & ~en_off);
      active_sel_r <= track ? insel_r : active_sel_r;
    end
  end

  // ----------------------------------------------------------------
  // result, lock, done flag and trigger sampling
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      result_r <= 10'h000;
      lock_r <= 1'b0;
      done_r <= 1'b0;
      trig_s1_r <= 7'h00;
      trig_s2_r <= 7'h00;
      trig_d_r <= 1'b0;
    end else begin
      if (finish & ~lock_r) begin
        result_r <= i_core_result;
      end
      lock_r <= rd_lo | (lock_r & ~rd_hi);
      done_r <= finish | (done_r & ~done_clr);
      trig_s1_r <= i_trig_src;
      trig_s2_r <= trig_s1_r;
      trig_d_r <= trig_lvl;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_done_sets_flag: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    finish |=> done_r)
    else $error("done flag not set at completion");

  a_single_clears_start: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (finish && !free_run && !start_pend_r && !sw_start) |=> (idle && !start_flag))
    else $error("start flag still high after single conversion");

  a_free_run_restart: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (finish && free_run && en_r) |=> (conv && hc_r == 6'h00 && start_flag))
    else $error("free running did not restart");

  a_trigger_starts: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    auto_go |=> (conv && hc_r == 6'h00 && end_r == acs_pkg::AUTO_HALF))
    else $error("trigger edge did not start conversion");

  a_edge_ignored_busy: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (conv && trig_edge && !finish && en_r) |=> (conv && hc_r == $past(hc_r) + 6'($past(step))))
    else $error("trigger edge restarted a running conversion");

  a_presc_held_off: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!en_r) |-> (!p_rise && !p_fall))
    else $error("prescaler ran while disabled");

  a_disable_aborts: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!en_r) |=> idle)
    else $error("conversion kept running while disabled");

  a_done_clears: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (done_clr && !finish) |=> !done_r)
    else $error("done flag not cleared by write");

  a_sw_start_on_rise: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (idle && $rose(conv) == 1'b0 && start_pend_r && en_r && !p_rise && !auto_go) |=> idle)
    else $error("software start did not wait for converter rise");

  a_result_locked: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (lock_r && !rd_hi) |=> $stable(result_r))
    else $error("result changed while locked");

  a_sel_frozen: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (conv && $past(conv) && hc_r + 6'h02 < end_r && $past(hc_r) + 6'h02 < $past(end_r))
      |-> $stable(active_sel_r))
    else $error("selection changed mid conversion");

endmodule : acs_adc_sequencer
`default_nettype wire

// [src/acs_pkg.sv]
package acs_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_CTRL_A = 5'h00;
  localparam logic [4:0] ADDR_CTRL_B = 5'h04;
  localparam logic [4:0] ADDR_INSEL = 5'h08;
  localparam logic [4:0] ADDR_RES_LO = 5'h0C;
  localparam logic [4:0] ADDR_RES_HI = 5'h10;
  localparam logic [4:0] ADDR_STATUS = 5'h14;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CA_EN = 0;
  localparam int CA_START = 1;
  localparam int CA_AUTO = 2;
  localparam int CA_DONE = 3;
  localparam int CA_PS_LSB = 4;
  localparam int CB_TS_LSB = 0;
  localparam int CB_DIFF = 3;
  localparam int ST_BUSY = 0;
  localparam int ST_LOCK = 1;
  localparam int ST_SYNC = 2;
  localparam int ST_SEL_LSB = 8;

  // ----------------------------------------------------------------
  // reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] PS_RST = 3'h0;
  localparam logic [2:0] TS_RST = 3'h0;
  localparam logic [7:0] INSEL_RST = 8'h00;
  localparam logic [2:0] TS_DONE = 3'h7;

  // ----------------------------------------------------------------
  // timing, in converter clock cycles and half cycles
  // ----------------------------------------------------------------
  localparam int NORMAL_CYC = 13;
  localparam int FIRST_CYC = 25;
  localparam int DIFF_EXTRA_CYC = 1;
  localparam int AUTO_SH_CYC = 2;
  localparam logic [5:0] NORMAL_HALF = 6'(2 * NORMAL_CYC);
  localparam logic [5:0] FIRST_HALF = 6'(2 * FIRST_CYC);
  localparam logic [5:0] DIFF_EXTRA_HALF = 6'(2 * DIFF_EXTRA_CYC);
  localparam logic [5:0] AUTO_HALF = 6'h1B;
  localparam logic [5:0] SH_NORMAL_HALF = 6'h03;
  localparam logic [5:0] SH_FIRST_HALF = 6'h1B;
  localparam logic [5:0] AUTO_SH_HALF = 6'(2 * AUTO_SH_CYC);

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } acs_state_t;

endpackage : acs_pkg

// [src/acs_prescaler.sv]
`timescale 1ns/1ps
`default_nettype none
module acs_prescaler (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // control
  input wire logic i_run,
  input wire logic i_clr,
  input wire logic [2:0] i_ps,
  // converter clock events
  output logic o_rise,
  output logic o_fall,
  output logic o_sync
);

  logic [6:0] cnt_r;
  logic sync_r;
  wire [7:0] div = (i_ps == 3'h0) ? 8'h02 : (8'h01 << i_ps);
  wire [6:0] top = 7'(div - 8'h01);
  wire [6:0] mid = 7'((div >> 1) - 8'h01);
  wire hold = ~i_run | i_clr;

  assign o_rise = ~hold & (cnt_r == top);
  assign o_fall = ~hold & (cnt_r == mid);
  assign o_sync = sync_r;

  // ----------------------------------------------------------------
  // divider, held at zero while stopped or cleared
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_r <= 7'h00;
      sync_r <= 1'b0;
    end else begin
      cnt_r <= (hold | o_rise) ? 7'h00 : cnt_r + 7'h01;
      sync_r <= ~i_run ? 1'b0 : (o_rise ? ~sync_r : sync_r);
    end
  end

endmodule : acs_prescaler
`default_nettype wire

// [verification/acs_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module acs_core_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // from sequencer
  input wire logic i_conv_active,
  input wire logic i_sample_hold,
  input wire logic [7:0] i_core_sel,
  // to sequencer
  output logic [9:0] o_core_result
);
  // ----------------------------------------------------------------
  // result: held from sample point, churning while idle
  // ----------------------------------------------------------------
  logic [9:0] held_r;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      held_r <= 10'h000;
    end else if (i_sample_hold) begin
      held_r <= {2'h2, i_core_sel};
    end else if (!i_conv_active) begin
      held_r <= ~held_r;
    end
  end
  assign o_core_result = held_r;
endmodule : acs_core_model
`default_nettype wire

// [verification/tb_acs_adc_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_acs_adc_sequencer;
  logic clk, sys_rst, rd, wr, wreq, core_en, conv, sh, sync_ck;
  logic [4:0] addr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0] be;
  logic [6:0] trig;
  logic [9:0] res;
  logic [7:0] sel;
  int fails, total_checks, conv_cnt, sh_cnt, gap, sh_gap, run, conv_len, n;

  // ----------------------------------------------------------------
  // design and core model
  // ----------------------------------------------------------------
  acs_adc_sequencer DUT (.i_clk(clk), .i_sys_rst(sys_rst), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_trig_src(trig),
    .i_core_result(res), .o_core_enable(core_en), .o_conv_active(conv),
    .o_sample_hold(sh), .o_core_sel(sel), .o_half_rate_sync_clock(sync_ck));
  acs_core_model core (.i_clk(clk), .i_sys_rst(sys_rst), .i_conv_active(conv),
    .i_sample_hold(sh), .i_core_sel(sel), .o_core_result(res));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // monitor: conversion count and length, sample spacing
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    gap <= gap + 1;
    if (sh === 1'b1) begin
      sh_cnt <= sh_cnt + 1;
      sh_gap <= gap + 1;
      gap <= 0;
    end
    if (conv === 1'b1 && run == 0) conv_cnt <= conv_cnt + 1;
    if (conv === 1'b1) run <= run + 1;
    else begin
      if (run != 0) conv_len <= run;
      run <= 0;
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check_eq(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check_eq

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    rv = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr_reg

  task automatic rd_chk(input string what, input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check_eq(what, exp, rv);
  endtask : rd_chk

  task automatic wait_for(input logic lvl);
    int k;
    k = 0;
    while (conv !== lvl && k < 400) begin
      @(posedge clk);
      k++;
    end
    if (k >= 400) fails++;
  endtask : wait_for

  task automatic run_conv;
    wait_for(1'b1);
    wait_for(1'b0);
    repeat (2) @(posedge clk);
  endtask : run_conv

  task automatic wait_sh(input int m);
    int k;
    k = 0;
    while (sh_cnt < m && k < 500) begin
      @(posedge clk);
      k++;
    end
    if (k >= 500) fails++;
  endtask : wait_sh

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #300us;
    fails++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    addr = 5'h00;
    wdata = 32'h0000_0000;
    be = 4'hF;
    trig = 7'h00;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd_chk("ctrl_a reset", acs_pkg::ADDR_CTRL_A, 32'h0000_0000);
    rd_chk("unmapped", 5'h18, 32'h0000_0000);
    wr_reg(acs_pkg::ADDR_INSEL, 32'h5A);
    wr_reg(acs_pkg::ADDR_CTRL_A, 32'h03);
    rd_chk("start busy", acs_pkg::ADDR_CTRL_A, 32'h03);
    wr_reg(acs_pkg::ADDR_INSEL, 32'hA5);
    check_eq("sel frozen", 32'h5A, {24'h0, sel});
    run_conv();
    check_eq("first len", 32'h32, 32'(conv_len));
    rd_chk("done start", acs_pkg::ADDR_CTRL_A, 32'h09);
    rd_chk("res lo", acs_pkg::ADDR_RES_LO, 32'h5A);
    rd_chk("res hi", acs_pkg::ADDR_RES_HI, 32'h02);
    check_eq("sel track", 32'hA5, {24'h0, sel});
    wr_reg(acs_pkg::ADDR_CTRL_A, 32'h0B);
    run_conv();
    check_eq("normal len", 32'h1A, 32'(conv_len));
    rd_chk("lock lo", acs_pkg::ADDR_RES_LO, 32'hA5);
    bus(1'b0, acs_pkg::ADDR_STATUS, 32'h0000_0000);
    check_eq("status lock", 32'h0000_A502, rv & 32'hFFFF_FFFB);
    wr_reg(acs_pkg::ADDR_INSEL, 32'h3C);
    wr_reg(acs_pkg::ADDR_CTRL_A, 32'h0B);
    run_conv();
    rd_chk("done lost", acs_pkg::ADDR_CTRL_A, 32'h09);
    rd_chk("kept lo", acs_pkg::ADDR_RES_LO, 32'hA5);
    rd_chk("kept hi", acs_pkg::ADDR_RES_HI, 32'h02);
    wr_reg(acs_pkg::ADDR_CTRL_A, 32'h0B);
    run_conv();
    rd_chk("new lo", acs_pkg::ADDR_RES_LO, 32'h3C);
    bus(1'b0, acs_pkg::ADDR_RES_HI, 32'h0000_0000);
    wr_reg(acs_pkg::ADDR_CTRL_A, 32'h0D);
    for (int s = 0; s < 7; s++) begin
      wr_reg(acs_pkg::ADDR_CTRL_B, 32'(s));
      n = conv_cnt;
      @(posedge clk);
      trig[s] <= 1'b1;
      wait_for(1'b1);
      bus(1'b0, acs_pkg::ADDR_CTRL_A, 32'h0000_0000);
      check_eq("auto busy", 32'h1, {31'h0, rv[acs_pkg::CA_START]});
      trig[s] <= 1'b0;
      repeat (3) @(posedge clk);
      trig[s] <= 1'b1;
      wait_for(1'b0);
      trig[(s + 1) % 7] <= 1'b1;
      repeat (60) @(posedge clk);
      check_eq("one per edge", 32'(n + 1), 32'(conv_cnt));
      trig <= 7'h00;
    end
    n = conv_cnt;
    wr_reg(acs_pkg::ADDR_CTRL_A, 32'h0F);
    run_conv();
    check_eq("sw under auto", 32'(n + 1), 32'(conv_cnt));
    wr_reg(acs_pkg::ADDR_CTRL_B, 32'h07);
    wr_reg(acs_pkg::ADDR_CTRL_A, 32'h0F);
    wait_sh(sh_cnt + 3);
    wr_reg(acs_pkg::ADDR_CTRL_A, 32'h0D);
    wait_sh(sh_cnt + 2);
    check_eq("free gap", 32'h1A, 32'(sh_gap));
    bus(1'b0, acs_pkg::ADDR_CTRL_A, 32'h0000_0000);
    check_eq("free start", 32'h1, {31'h0, rv[acs_pkg::CA_START]});
    wr_reg(acs_pkg::ADDR_CTRL_B, 32'h0F);
    wait_sh(sh_cnt + 3);
    check_eq("diff gap", 32'h1C, 32'(sh_gap));
    wr_reg(acs_pkg::ADDR_CTRL_A, 32'h00);
    repeat (40) @(posedge clk);
    check_eq("disabled", 32'h0, {29'h0, core_en, conv, sync_ck});
    wr_reg(acs_pkg::ADDR_CTRL_B, 32'h08);
    wr_reg(acs_pkg::ADDR_CTRL_A, 32'h03);
    run_conv();
    wr_reg(acs_pkg::ADDR_CTRL_A, 32'h0B);
    run_conv();
    check_eq("diff single", 32'h1, {31'h0, conv_len == 26 || conv_len == 28});
    wr_reg(acs_pkg::ADDR_CTRL_A, 32'h00);
    wr_reg(acs_pkg::ADDR_CTRL_A, 32'h05);
    n = conv_cnt;
    @(posedge clk);
    trig[0] <= 1'b1;
    run_conv();
    check_eq("diff auto", 32'(n + 1), 32'(conv_cnt));
    trig <= 7'h00;
    tally_and_finish();
  end
endmodule : tb_acs_adc_sequencer
`default_nettype wire
